//--- rtl/apcs_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module apcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push, pop;

  // handshakes and honest flags
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointer and level update
  always_comb begin
    wrPtr_nxt = push ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt = pop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = (AW+1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = (AW+1)'(count_r - 1'b1);
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  chk_no_overflow: assert property (@(posedge clk) disable iff (rst)
    (count_r == (AW+1)'(DEPTH)) |=> (count_r != '0))
    else $error("fifo level wrapped from full to empty");
endmodule : apcs_fifo
`default_nettype wire

//--- rtl/apcs_pkg.sv
// shared constants for the ahb port chip-select decode block
`default_nettype none
package apcs_pkg;
  // transfer type encodings
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_BUSY   = 2'h1;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  // transfer size encodings
  localparam logic [2:0] SIZE_BYTE    = 3'h0;
  localparam logic [2:0] SIZE_HALF    = 3'h1;
  localparam logic [2:0] SIZE_WORD    = 3'h2;
  // response encodings
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_ERROR   = 2'h1;
  // widths and depths
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 28;
  localparam int SEL_W      = 8;
  localparam int CS_W       = 4;
  localparam int FIFO_DEPTH = 32;
  // select line positions of the first dynamic chip select
  localparam int DYN_BASE   = 4;
  // write entry layout: data, address, size, static flag, cs index, write flag
  localparam int ENTRY_W    = DATA_W + ADDR_W + 3 + 1 + 2 + 1;
  // bit positions inside a packed write entry
  localparam int ENT_WRITE  = 0;
  localparam int ENT_CS_LSB = 1;
  localparam int ENT_STATIC = 3;
  localparam int ENT_SIZE   = 4;
  localparam int ENT_ADDR   = 7;
  localparam int ENT_DATA   = ENT_ADDR + ADDR_W;
endpackage : apcs_pkg
`default_nettype wire

//--- rtl/apcs_port_decode.sv
// ahb port front end: chip-select routing, size check, write fifo
`timescale 1ns/10ps
`default_nettype none
module apcs_port_decode #(
  parameter int DEPTH = apcs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // ahb address phase
  input  wire logic                         portGlobalSelect,
  input  wire logic [apcs_pkg::SEL_W-1:0]   portChipSelectLines,
  input  wire logic [apcs_pkg::ADDR_W-1:0]  hAddr,
  input  wire logic [1:0]                   hTrans,
  input  wire logic [2:0]                   hSize,
  input  wire logic [2:0]                   hBurst,
  input  wire logic                         hWrite,
  input  wire logic                         hReadyIn,
  // ahb data phase
  input  wire logic [apcs_pkg::DATA_W-1:0]  hWData,
  output logic                              hReadyOut,
  output logic      [1:0]                   hResp,
  // memory engine command stream
  output logic                              memValid,
  input  wire logic                         memReady,
  output logic                              memWrite,
  output logic      [apcs_pkg::ADDR_W-1:0]  memAddr,
  output logic      [2:0]                   memSize,
  output logic      [apcs_pkg::DATA_W-1:0]  memWData,
  output logic      [apcs_pkg::CS_W-1:0]    staticMemChipSelectOut,
  output logic      [apcs_pkg::CS_W-1:0]    dynamicMemChipSelectOut
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_ERR1, ST_ERR2} apcs_state_e;

  // one-hot select line to static flag and chip-select index
  function automatic logic [2:0] route(input logic [apcs_pkg::SEL_W-1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < apcs_pkg::SEL_W; i++) begin
      if (sel[i]) begin
        r = {(i < apcs_pkg::DYN_BASE), 2'(i % apcs_pkg::CS_W)};
      end
    end
    return r;
  endfunction : route

  // chip-select index to one-hot select vector
  function automatic logic [apcs_pkg::CS_W-1:0] selOneHot(input logic [1:0] idx);
    logic [apcs_pkg::CS_W-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction : selOneHot

  localparam int EW = apcs_pkg::ENTRY_W;

  apcs_state_e                  state_r, state_nxt;
  logic [apcs_pkg::ADDR_W-1:0]  addr_r, addr_nxt;
  logic [2:0]                   size_r, size_nxt;
  logic [2:0]                   cs_r, cs_nxt;
  logic                         write_r, write_nxt;
  logic                         hReadyOut_r, hReadyOut_nxt;
  logic [1:0]                   hResp_r, hResp_nxt;
  logic                         memValid_r, memValid_nxt;
  logic [EW-1:0]                ent_r, ent_nxt;
  logic [apcs_pkg::CS_W-1:0]    stCs_r, stCs_nxt;
  logic [apcs_pkg::CS_W-1:0]    dyCs_r, dyCs_nxt;
  logic                         take, sizeBad, fifoInReady, fifoOutValid, fifoInValid;
  logic [EW-1:0]                fifoOut;

  // address phase is accepted while selected, ready and an active type
  assign take = portGlobalSelect && hReadyIn && hReadyOut_r
                && hTrans[1];
  assign sizeBad = (hSize > apcs_pkg::SIZE_WORD);
  // data phase pushes one entry carrying the write data
  assign fifoInValid = (state_r == ST_DATA);

  // phase tracking and response generation
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    size_nxt      = size_r;
    cs_nxt        = cs_r;
    write_nxt     = write_r;
    hReadyOut_nxt = hReadyOut_r;
    hResp_nxt     = apcs_pkg::RESP_OKAY;
    unique case (state_r)
      ST_IDLE, ST_ERR2: begin
        hReadyOut_nxt = 1'b1;
        state_nxt     = ST_IDLE;
        if (take) begin
          addr_nxt  = hAddr;
          size_nxt  = hSize;
          cs_nxt    = route(portChipSelectLines);
          write_nxt = hWrite;
          if (sizeBad) begin
            state_nxt     = ST_ERR1;
            hReadyOut_nxt = 1'b0;
            hResp_nxt     = apcs_pkg::RESP_ERROR;
          end else begin
            state_nxt     = ST_DATA;
            hReadyOut_nxt = 1'b0;
          end
        end
      end
      ST_DATA: begin
        hReadyOut_nxt = 1'b0;
        if (fifoInReady) begin
          state_nxt     = ST_IDLE; // entry accepted, finish beat
          hReadyOut_nxt = 1'b1;
        end
      end
      ST_ERR1: begin
        state_nxt     = ST_ERR2; // second error cycle
        hReadyOut_nxt = 1'b1;
        hResp_nxt     = apcs_pkg::RESP_ERROR;
      end
    endcase
  end

  // packed entry: data, addr, size, static flag + index, write
  always_comb begin
    ent_nxt      = ent_r;
    memValid_nxt = memValid_r;
    stCs_nxt     = stCs_r;
    dyCs_nxt     = dyCs_r;
    if (!memValid_r || memReady) begin
      memValid_nxt = fifoOutValid;
      stCs_nxt     = '0;
      dyCs_nxt     = '0;
      if (fifoOutValid) begin
        ent_nxt = fifoOut;
        if (fifoOut[apcs_pkg::ENT_STATIC]) begin
          stCs_nxt = selOneHot(fifoOut[apcs_pkg::ENT_CS_LSB +: 2]);
        end else begin
          dyCs_nxt = selOneHot(fifoOut[apcs_pkg::ENT_CS_LSB +: 2]);
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      addr_r      <= '0;
      size_r      <= apcs_pkg::SIZE_BYTE;
      cs_r        <= '0;
      write_r     <= 1'b0;
      hReadyOut_r <= 1'b1;
      hResp_r     <= apcs_pkg::RESP_OKAY;
      memValid_r  <= 1'b0;
      ent_r       <= '0;
      stCs_r      <= '0;
      dyCs_r      <= '0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      size_r      <= size_nxt;
      cs_r        <= cs_nxt;
      write_r     <= write_nxt;
      hReadyOut_r <= hReadyOut_nxt;
      hResp_r     <= hResp_nxt;
      memValid_r  <= memValid_nxt;
      ent_r       <= ent_nxt;
      stCs_r      <= stCs_nxt;
      dyCs_r      <= dyCs_nxt;
    end
  end

  // write data queued with its command toward memory
  apcs_fifo #(.WIDTH(EW), .DEPTH(DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   ({hWData, addr_r, size_r, cs_r, write_r}),
    .outValid (fifoOutValid),
    .outReady (!memValid_r || memReady),
    .outData  (fifoOut)
  );

  // output stage taken straight from registers
  assign hReadyOut = hReadyOut_r;
  assign hResp     = hResp_r;
  assign memValid  = memValid_r;
  assign memWrite  = ent_r[apcs_pkg::ENT_WRITE];
  assign memSize   = ent_r[apcs_pkg::ENT_SIZE +: 3];
  assign memAddr   = ent_r[apcs_pkg::ENT_ADDR +: apcs_pkg::ADDR_W];
  assign memWData  = ent_r[apcs_pkg::ENT_DATA +: apcs_pkg::DATA_W];
  // active-high one-hot chip selects, registered with the held command
  assign staticMemChipSelectOut  = stCs_r;
  assign dynamicMemChipSelectOut = dyCs_r;

  // a two-cycle error: low-ready error, then high-ready error
  sequence s_errFirst;
    !hReadyOut && hResp == apcs_pkg::RESP_ERROR;
  endsequence
  sequence s_errSecond;
    hReadyOut && hResp == apcs_pkg::RESP_ERROR;
  endsequence

  chk_oversize_error: assert property (@(posedge clk) disable iff (rst)
    take && sizeBad |=> s_errFirst ##1 s_errSecond)
    else $error("oversize transfer not answered with two-cycle error");
  chk_no_retry_split: assert property (@(posedge clk) disable iff (rst)
    hResp == apcs_pkg::RESP_OKAY || hResp == apcs_pkg::RESP_ERROR)
    else $error("response other than okay or error");
  chk_idle_no_work: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_IDLE && !hTrans[1] |=> state_r == ST_IDLE)
    else $error("idle or busy transfer started memory work");
  chk_good_size_data: assert property (@(posedge clk) disable iff (rst)
    take && !sizeBad |=> state_r == ST_DATA && hResp == apcs_pkg::RESP_OKAY)
    else $error("legal size transfer not carried out");
  chk_static_route: assert property (@(posedge clk) disable iff (rst)
    take && portChipSelectLines == 8'h02 |=> cs_r == 3'h5)
    else $error("select line 1 not routed to static select 1");
  chk_dynamic_route: assert property (@(posedge clk) disable iff (rst)
    take && portChipSelectLines == 8'h80 |=> cs_r == 3'h3)
    else $error("select line 7 not routed to dynamic select 3");
  chk_write_dir: assert property (@(posedge clk) disable iff (rst)
    take |=> write_r == $past(hWrite))
    else $error("direction not captured from transfer");
  chk_wdata_pass: assert property (@(posedge clk) disable iff (rst)
    fifoInValid && fifoInReady && !fifoOutValid && !memValid_r
    |=> ##1 memValid && memWData == $past(hWData, 2))
    else $error("write data not passed toward memory");
  chk_one_select: assert property (@(posedge clk) disable iff (rst)
    $onehot0(staticMemChipSelectOut | dynamicMemChipSelectOut))
    else $error("more than one memory chip select active");
endmodule : apcs_port_decode
`default_nettype wire

//--- verification/ahb_port_chip_select_decode_test.sv
// self-checking bench for the port chip-select decode block
`timescale 1ns/10ps
`default_nettype none
module ahb_port_chip_select_decode_test;
  logic        clk = 0, rst = 1, gSel = 0, hWrite = 0, stall = 0;
  logic [7:0]  csLines = 8'h00;
  logic [1:0]  hTrans = 2'h0;
  logic [2:0]  hSize = 3'h0, hBurst = 3'h0;
  logic [27:0] hAddr = 28'h0;
  logic [31:0] hWData = 32'h0;
  logic        hReadyOut, memValid, memReady, memWrite;
  logic [1:0]  hResp, resp;
  logic [2:0]  memSize;
  logic [31:0] memWData;
  logic [3:0]  stCs, dyCs;
  logic [43:0] lastCmd;
  logic [27:0] memAddr, lastAddr;
  int          cmdCount, waits, expN = 0, miscompares = 0, nChecks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  apcs_port_decode #(.DEPTH(4)) uut (.clk(clk), .rst(rst), .portGlobalSelect(gSel),
    .portChipSelectLines(csLines), .hAddr(hAddr), .hTrans(hTrans), .hSize(hSize),
    .hBurst(hBurst), .hWrite(hWrite), .hReadyIn(hReadyOut), .hWData(hWData),
    .hReadyOut(hReadyOut), .hResp(hResp), .memValid(memValid), .memReady(memReady),
    .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize), .memWData(memWData),
    .staticMemChipSelectOut(stCs), .dynamicMemChipSelectOut(dyCs));
  apcs_mem_sink sink (.clk(clk), .rst(rst), .memValid(memValid), .memReady(memReady),
    .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize), .memWData(memWData),
    .stCs(stCs), .dyCs(dyCs), .stall(stall), .lastCmd(lastCmd), .lastAddr(lastAddr),
    .cmdCount(cmdCount));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [43:0] seen, input logic [43:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // expected command: direction, size, data, static and dynamic selects
  function automatic logic [43:0] cmd(int cs, logic wr, logic [2:0] sz, logic [31:0] d);
    return {wr, sz, d, cs < 4 ? 4'h1 << cs : 4'h0, cs > 3 ? 4'h1 << (cs - 4) : 4'h0};
  endfunction : cmd

  // one beat: address phase, then data phase until ready is sampled high
  task automatic xfer(input int cs, input logic [1:0] tr, input logic [2:0] sz,
                      input logic wr, input logic [31:0] d);
    gSel    <= 1'b1;
    csLines <= 8'h01 << cs;
    hTrans  <= tr;
    hSize   <= sz;
    hWrite  <= wr;
    hAddr   <= 28'(cs * 16);
    @(posedge clk);
    gSel    <= 1'b0;
    csLines <= 8'h00;
    hTrans  <= 2'h0;
    hWData  <= d;
    waits = 0;
    @(posedge clk);
    while (hReadyOut !== 1'b1 && waits < 40) begin
      if (waits == 12) stall <= 1'b0;
      waits++;
      @(posedge clk);
    end
    if (waits == 40) begin
      miscompares++;
      print_verdict();
    end
    resp = hResp;
    chk("resp kind", 44'(resp[1]), 44'h0);
  endtask : xfer

  // bounded wait for the n-th command, then compare it
  task automatic expect_cmd(input int n, input logic [43:0] exp, input logic [27:0] addr);
    for (int i = 0; i < 40 && cmdCount < n; i++) @(posedge clk);
    if (cmdCount < n) begin
      miscompares++;
      print_verdict();
    end
    chk("cmd count", 44'(cmdCount), 44'(n));
    chk("cmd fields", lastCmd, exp);
    chk("cmd address", 44'(lastAddr), 44'(addr));
  endtask : expect_cmd

  // each select line reaches its own chip select with the write data
  task automatic t_route();
    for (int cs = 0; cs < 8; cs++) begin
      xfer(cs, 2'h2, 3'h2, 1'b1, 32'ha5a50000 + cs);
      chk("okay", 44'(resp), 44'h0);
      expN++;
      expect_cmd(expN, cmd(cs, 1'b1, 3'h2, 32'ha5a50000 + cs),
                 28'(cs * 16));
    end
  endtask : t_route

  // legal sizes become reads, wider sizes are refused with no command
  task automatic t_sizes();
    for (int sz = 0; sz < 8; sz++) begin
      xfer(1, 2'h3, 3'(sz), 1'b0, hWData);
      if (sz < 3) begin
        chk("okay", 44'(resp), 44'h0);
        expN++;
        expect_cmd(expN, cmd(1, 1'b0, 3'(sz), hWData), 28'h10);
      end else begin
        chk("error", 44'(resp), 44'h1);
        repeat (8) @(posedge clk);
        chk("no cmd", 44'(cmdCount), 44'(expN));
      end
    end
  endtask : t_sizes

  // idle and busy cycles start no work
  task automatic t_idle();
    for (int tr = 0; tr < 2; tr++) begin
      xfer(2, 2'(tr), 3'h2, 1'b1, 32'h5);
      chk("no wait", 44'(waits), 44'h0);
    end
    repeat (8) @(posedge clk);
    chk("no cmd", 44'(cmdCount), 44'(expN));
  endtask : t_idle

  // wrapping and incrementing bursts of 4, 8 and 16 beats back to back
  task automatic t_burst();
    for (int b = 2; b < 8; b++) begin
      hBurst <= 3'(b);
      for (int i = 0; i < (4 << ((b - 2) / 2)); i++) begin
        xfer(6, i == 0 ? 2'h2 : 2'h3, 3'h1, 1'b1, 32'h1000 + i);
        expN++;
      end
      expect_cmd(expN, cmd(6, 1'b1, 3'h1, 32'h1000 + (4 << ((b - 2) / 2)) - 1),
                 28'h60);
    end
  endtask : t_burst

  // stalled engine fills the buffer until refused, then drains to empty
  task automatic t_fill();
    logic refused;
    refused = 1'b0;
    stall <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      xfer(0, 2'h2, 3'h0, 1'b1, 32'(i));
      if (waits >= 12) refused = 1'b1;
    end
    expN += 10;
    expect_cmd(expN, cmd(0, 1'b1, 3'h0, 32'h9), 28'h0);
    chk("refused", 44'(refused), 44'h1);
    chk("drained", 44'(memValid), 44'h0);
  endtask : t_fill

  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_route();
    t_sizes();
    t_idle();
    t_burst();
    t_fill();
    print_verdict();
  end
endmodule : ahb_port_chip_select_decode_test
`default_nettype wire

//--- verification/apcs_mem_sink.sv
// memory engine stand-in: takes commands, can stall, records the last one
`timescale 1ns/10ps
`default_nettype none
module apcs_mem_sink (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // command stream from the port
  input  wire logic        memValid,
  output logic             memReady,
  input  wire logic        memWrite,
  input  wire logic [27:0] memAddr,
  input  wire logic [2:0]  memSize,
  input  wire logic [31:0] memWData,
  input  wire logic [3:0]  stCs,
  input  wire logic [3:0]  dyCs,
  // stall control and capture
  input  wire logic        stall,
  output logic      [43:0] lastCmd,
  output logic      [27:0] lastAddr,
  output var int           cmdCount
);
  // slow engine: refuses while stalled
  assign memReady = !stall;
  // record every command taken
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdCount <= 0;
      lastCmd  <= 44'h0;
      lastAddr <= 28'h0;
    end else if (memValid && memReady) begin
      cmdCount <= cmdCount + 1;
      lastCmd  <= {memWrite, memSize, memWData, stCs, dyCs};
      lastAddr <= memAddr;
    end
  end
endmodule : apcs_mem_sink
`default_nettype wire
